// File: rtl/card_load_consts.svh
// constants for the card store load and autoload block
`ifndef CARD_LOAD_CONSTS_SVH
`define CARD_LOAD_CONSTS_SVH
`define CLK_MHZ 20
`define PULSE1_NS 4000
`define PULSE2_NS 100
`define PULSE1_CYC ((`PULSE1_NS * `CLK_MHZ) / 1000)
`define PULSE2_CYC (((`PULSE2_NS * `CLK_MHZ) + 999) / 1000)
`define RTC_PERIOD_US 16384
`define RTC_CYC (`RTC_PERIOD_US * `CLK_MHZ)
`define START_ADDR_DISC 16'h0113
`define START_ADDR_CARD 16'h0112
`define EXEC_PROC_BIT 4
`define NYB_FIRST 2'h0
`define NYB_LAST 2'h3
`define WORD_W 16
`define NYB_W 4
`endif

// File: rtl/card_load_pkg.sv
// types for the card store load and autoload block
package card_load_pkg;
    typedef enum logic [3:0] {
        AL_IDLE = 4'h1,
        AL_RESET = 4'h2,
        AL_REQ = 4'h4,
        AL_RUN = 4'h8
    } autoload_state_e;
    typedef logic [1:0] nybble_count_t;
endpackage : card_load_pkg

// File: rtl/card_link_if.sv
// link between the load control logic and a card adapter
`timescale 1ns/1ps
interface card_link_if;
    logic operation_active;
    logic head_position_signal;
    logic adapter_output_strobe;
    logic [3:0] nybble_input_lines;
    logic card_input_done;
    modport device (
        output operation_active,
        output head_position_signal,
        input adapter_output_strobe,
        input nybble_input_lines,
        input card_input_done
    );
    modport adapter (
        input operation_active,
        input head_position_signal,
        output adapter_output_strobe,
        output nybble_input_lines,
        output card_input_done
    );
endinterface : card_link_if

// File: rtl/pulse_timer.sv
// one-shot timer of a fixed number of cycles
`timescale 1ns/1ps
module pulse_timer #(
    parameter int CYCLES = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // trigger and pulse
    input wire logic fire,
    output logic active,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (fire) begin
                cnt_r <= CW'(CYCLES);
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == CW'(1)) begin
                    done <= 1'b1;
                end
            end
        end
    end
    assign active = (cnt_r != '0);
endmodule : pulse_timer

// File: rtl/card_adapter_end.sv
// card adapter end: delivers words as four nybbles
`timescale 1ns/1ps
`include "card_load_consts.svh"
module card_adapter_end (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link
    card_link_if.adapter link,
    // user side
    input wire logic [15:0] word_data,
    input wire logic word_valid,
    input wire logic last_word,
    output logic word_ready,
    output logic load_active
);
    logic [15:0] shift_r;
    logic [2:0] left_r;
    logic last_r;
    logic strobe_r;
    logic [3:0] nyb_r;
    logic done_r;
    logic ready_r;
    logic act_r;
    // ==========================================================
    // nybble transmitter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_r <= 16'h0000;
            left_r <= 3'h0;
            last_r <= 1'b0;
            strobe_r <= 1'b0;
            nyb_r <= 4'h0;
            done_r <= 1'b0;
            ready_r <= 1'b0;
            act_r <= 1'b0;
        end else begin
            act_r <= link.operation_active;
            strobe_r <= 1'b0;
            done_r <= 1'b0;
            ready_r <= link.operation_active && left_r == 3'h0 && !word_ready;
            if (!link.operation_active) begin
                left_r <= 3'h0;
                ready_r <= 1'b0;
            end else if (left_r == 3'h0 && word_valid && word_ready) begin
                shift_r <= word_data;
                last_r <= last_word;
                left_r <= 3'h4;
                ready_r <= 1'b0;
            end else if (left_r != 3'h0 && !strobe_r) begin
                nyb_r <= shift_r[15:12];
                shift_r <= {shift_r[11:0], 4'h0};
                strobe_r <= 1'b1;
                left_r <= left_r - 3'h1;
                if (left_r == 3'h1 && last_r) begin
                    done_r <= 1'b1;
                end
            end
        end
    end
    assign word_ready = ready_r;
    assign load_active = act_r;
    assign link.adapter_output_strobe = strobe_r;
    assign link.nybble_input_lines = nyb_r;
    assign link.card_input_done = done_r;
endmodule : card_adapter_end

// File: rtl/card_load_ctrl.sv
// control store card load and autoload control
//
// Overview of operation
// - start card load on power-on or reset/load
// - card position clears autoload-source, disc select low
// - reset/load raises operation-active, master clear, head signal
// - adapter ignores the head positioning signal
// - word built from four 4-bit nybbles
// - two-bit counter steers nybbles into data register
// - one adapter strobe clocks one nybble
// - nybble 0 raises first flag and assembly clear
// - nybble 3 raises last flag, store trigger, request
// - busy cleared by load-stop and console state
// - end of input clears operation-active
// - automatic autoload only after power-on or reset/load
// - button or disc request sets autoload flip-flop
// - 4 us pulse sets system reset, clears microaddress
// - 0.1 us pulse sets executive request and enable
// - executive request drives processor 4 busy bit
// - force start address 0113 disc, 0112 card
// - null state clears executive request
// - clock overflow raises request when enabled
// - main store transfer under microcode control only
`timescale 1ns/1ps
`include "card_load_consts.svh"
module card_load_ctrl #(
    parameter int RTC_CYCLES = `RTC_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link
    card_link_if.device link,
    // panel
    input wire logic power_on_reset,
    input wire logic reset_load_button,
    input wire logic card_source_selected,
    input wire logic autoload_button,
    input wire logic auto_mode,
    // disc and slot allocator
    input wire logic disc_autoload_request,
    input wire logic disc_load_done,
    input wire logic load_stop,
    input wire logic console_state_flag,
    input wire logic null_state,
    // outputs
    output logic disc_source_select,
    output logic load_master_clear,
    output logic [15:0] console_data,
    output logic first_nybble_flag,
    output logic last_nybble_flag,
    output logic assembly_clear,
    output logic word_store_trigger,
    output logic panel_store_request,
    output logic reset_clear_first,
    output logic reset_clear_second,
    output logic exec_request,
    output logic request_enable,
    output logic [7:0] busy_active,
    output logic force_address_valid,
    output logic [15:0] force_address
);
    logic op_active_r;
    logic head_r;
    logic disc_sel_r;
    logic mclr_r;
    card_load_pkg::nybble_count_t nyb_cnt_r;
    logic [15:0] data_r;
    logic first_r;
    logic last_r;
    logic clr_r;
    logic run_r;
    logic busy_r;
    logic auto_armed_r;
    logic auto_ff_r;
    logic sysrst_r;
    logic req_r;
    logic en_r;
    logic [7:0] ba_r;
    logic fav_r;
    logic [15:0] fa_r;
    logic [$clog2(RTC_CYCLES+1)-1:0] rtc_r;
    logic rtc_ovf;
    logic start_load;
    logic nybble_counter_clock;
    logic p1_act;
    logic p1_done;
    logic p2_act;
    logic p2_done;
    logic auto_start;
    card_load_pkg::autoload_state_e al_r;
    assign start_load = power_on_reset | reset_load_button;
    assign nybble_counter_clock = link.adapter_output_strobe & op_active_r;
    // ==========================================================
    // load initiate
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_active_r <= 1'b0;
            mclr_r <= 1'b0;
            head_r <= 1'b0;
            disc_sel_r <= 1'b1;
        end else begin
            if (card_source_selected) begin
                disc_sel_r <= 1'b0;
            end else begin
                disc_sel_r <= 1'b1;
            end
            mclr_r <= start_load;
            head_r <= mclr_r;
            if (start_load) begin
                op_active_r <= 1'b1;
            end else if (link.card_input_done || disc_load_done) begin
                op_active_r <= 1'b0;
            end
        end
    end
    // ==========================================================
    // nybble assembly
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nyb_cnt_r <= `NYB_FIRST;
            data_r <= 16'h0000;
            first_r <= 1'b0;
            last_r <= 1'b0;
            clr_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            first_r <= 1'b0;
            last_r <= 1'b0;
            clr_r <= 1'b0;
            run_r <= last_r;
            if (start_load) begin
                nyb_cnt_r <= `NYB_FIRST;
            end else if (nybble_counter_clock) begin
                nyb_cnt_r <= nyb_cnt_r + 2'h1;
                case (nyb_cnt_r)
                    2'h0: begin
                        data_r <= {link.nybble_input_lines, 12'h000};
                        first_r <= 1'b1;
                        clr_r <= 1'b1;
                    end
                    2'h1: data_r[11:8] <= link.nybble_input_lines;
                    2'h2: data_r[7:4] <= link.nybble_input_lines;
                    2'h3: begin
                        data_r[3:0] <= link.nybble_input_lines;
                        last_r <= 1'b1;
                    end
                    default: data_r <= data_r;
                endcase
            end
        end
    end
    // ==========================================================
    // panel busy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
        end else if (run_r) begin
            busy_r <= 1'b1;
        end else if (load_stop && console_state_flag) begin
            busy_r <= 1'b0;
        end
    end
    // ==========================================================
    // autoload start
    assign auto_start = (auto_armed_r && auto_mode && !op_active_r) || autoload_button || disc_autoload_request;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            auto_armed_r <= 1'b0;
            auto_ff_r <= 1'b0;
        end else begin
            if (start_load) begin
                auto_armed_r <= 1'b1;
            end else if (auto_ff_r) begin
                auto_armed_r <= 1'b0;
            end
            if (auto_start && al_r == card_load_pkg::AL_IDLE && !auto_ff_r) begin
                auto_ff_r <= 1'b1;
            end else if (al_r == card_load_pkg::AL_RUN && !autoload_button && !disc_autoload_request) begin
                auto_ff_r <= 1'b0;
            end
        end
    end
    pulse_timer #(.CYCLES(`PULSE1_CYC)) u_pulse1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .fire(al_r == card_load_pkg::AL_IDLE && auto_ff_r),
        .active(p1_act),
        .done(p1_done)
    );
    pulse_timer #(.CYCLES(`PULSE2_CYC)) u_pulse2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .fire(p1_done),
        .active(p2_act),
        .done(p2_done)
    );
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            al_r <= card_load_pkg::AL_IDLE;
        end else begin
            case (al_r)
                card_load_pkg::AL_IDLE: if (auto_ff_r) al_r <= card_load_pkg::AL_RESET;
                card_load_pkg::AL_RESET: if (p1_done) al_r <= card_load_pkg::AL_REQ;
                card_load_pkg::AL_REQ: if (p2_done) al_r <= card_load_pkg::AL_RUN;
                card_load_pkg::AL_RUN: if (!auto_ff_r) al_r <= card_load_pkg::AL_IDLE;
                default: al_r <= card_load_pkg::AL_IDLE;
            endcase
        end
    end
    // ==========================================================
    // system reset and executive request
    assign rtc_ovf = (rtc_r == '0);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rtc_r <= '0;
        end else if (rtc_ovf) begin
            rtc_r <= ($clog2(RTC_CYCLES+1))'(RTC_CYCLES - 1);
        end else begin
            rtc_r <= rtc_r - 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sysrst_r <= 1'b0;
            req_r <= 1'b0;
            en_r <= 1'b0;
            ba_r <= 8'h00;
            fav_r <= 1'b0;
            fa_r <= 16'h0000;
        end else begin
            sysrst_r <= p1_act;
            if (p2_act) begin
                req_r <= 1'b1;
                en_r <= 1'b1;
            end else if (rtc_ovf && en_r) begin
                req_r <= 1'b1;
            end else if (null_state) begin
                req_r <= 1'b0;
            end
            ba_r <= 8'h00;
            ba_r[`EXEC_PROC_BIT] <= req_r | (rtc_ovf & en_r);
            fav_r <= req_r && al_r == card_load_pkg::AL_RUN;
            fa_r <= card_source_selected ? `START_ADDR_CARD : `START_ADDR_DISC;
        end
    end
    assign link.operation_active = op_active_r;
    assign link.head_position_signal = head_r;
    assign disc_source_select = disc_sel_r;
    assign load_master_clear = mclr_r;
    assign console_data = data_r;
    assign first_nybble_flag = first_r;
    assign last_nybble_flag = last_r;
    assign assembly_clear = clr_r;
    assign word_store_trigger = run_r;
    assign panel_store_request = busy_r;
    assign reset_clear_first = sysrst_r;
    assign reset_clear_second = sysrst_r;
    assign exec_request = req_r;
    assign request_enable = en_r;
    assign busy_active = ba_r;
    assign force_address_valid = fav_r;
    assign force_address = fa_r;
endmodule : card_load_ctrl

// File: testbench/card_load_sva.sv
// checker for the card load link and the autoload sequence
`timescale 1ns/1ps
module card_load_sva (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link
    input wire logic operation_active,
    input wire logic head_position_signal,
    input wire logic adapter_output_strobe,
    input wire logic card_input_done,
    // panel and allocator
    input wire logic power_on_reset,
    input wire logic reset_load_button,
    input wire logic load_stop,
    input wire logic console_state_flag,
    input wire logic null_state,
    // control outputs
    input wire logic load_master_clear,
    input wire logic first_nybble_flag,
    input wire logic last_nybble_flag,
    input wire logic assembly_clear,
    input wire logic word_store_trigger,
    input wire logic panel_store_request,
    input wire logic reset_clear_first,
    input wire logic exec_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0] nyb_r;
    logic [7:0] rc_cnt_r;
    // =====================================
    // helper counters
    always_ff @(posedge clk) begin
        if (sys_rst || !operation_active) nyb_r <= 2'h0;
        else if (adapter_output_strobe) nyb_r <= nyb_r + 2'h1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst || !reset_clear_first) rc_cnt_r <= 8'h00;
        else rc_cnt_r <= rc_cnt_r + 8'h01;
    end
    // =====================================
    // assertions
    sequence take_s;
        adapter_output_strobe && operation_active;
    endsequence
    sequence store_s;
        last_nybble_flag ##1 word_store_trigger ##1 panel_store_request;
    endsequence
    first_flag_a: assert property (take_s ##0 nyb_r == 2'h0 |=> first_nybble_flag && assembly_clear)
        else $error("first nybble flag or clear missing");
    nyb_order_a: assert property (take_s ##0 nyb_r != 2'h0 |=> !first_nybble_flag)
        else $error("first nybble flag on a later nybble");
    last_flag_a: assert property (take_s ##0 nyb_r == 2'h3 |=> store_s)
        else $error("store steps missing after last nybble");
    busy_clear_a: assert property (panel_store_request && load_stop && console_state_flag
        && !word_store_trigger |=> !panel_store_request)
        else $error("panel request not cleared");
    input_done_a: assert property (card_input_done && !reset_load_button && !power_on_reset
        |=> !operation_active)
        else $error("operation active kept after end of input");
    head_sig_a: assert property (load_master_clear |=> head_position_signal)
        else $error("head signal missing after master clear");
    reset_width_a: assert property ($fell(reset_clear_first) |-> rc_cnt_r == 8'h50)
        else $error("reset clear width wrong");
    exec_after_a: assert property ($fell(reset_clear_first) |-> ##[1:4] exec_request)
        else $error("executive request not set after reset clear");
    null_clear_a: assert property (exec_request && null_state && $past(exec_request, 4)
        |=> !exec_request)
        else $error("executive request not cleared by null state");
endmodule : card_load_sva

// File: testbench/tb_card_store_load_and_autoload.sv
// testbench joining the load control and the card adapter end
`timescale 1ns/1ps
module tb_card_store_load_and_autoload;
    logic clk, sys_rst, power_on_reset, reset_load_button, card_source_selected, autoload_button, auto_mode;
    logic disc_autoload_request, disc_load_done, load_stop, console_state_flag, null_state;
    logic disc_source_select, load_master_clear, first_nybble_flag, last_nybble_flag, assembly_clear;
    logic word_store_trigger, panel_store_request, reset_clear_first, reset_clear_second;
    logic exec_request, request_enable, force_address_valid, word_valid, last_word, word_ready, load_active;
    logic [15:0] console_data, force_address, word_data;
    logic [7:0] busy_active;
    int n_fail, checks_done;
    card_link_if card_link_if_inst ();
    card_load_ctrl #(.RTC_CYCLES(200)) card_load_ctrl_inst (.clk, .sys_rst, .link(card_link_if_inst),
        .power_on_reset, .reset_load_button, .card_source_selected, .autoload_button, .auto_mode,
        .disc_autoload_request, .disc_load_done, .load_stop, .console_state_flag, .null_state,
        .disc_source_select, .load_master_clear, .console_data, .first_nybble_flag, .last_nybble_flag,
        .assembly_clear, .word_store_trigger, .panel_store_request, .reset_clear_first, .reset_clear_second,
        .exec_request, .request_enable, .busy_active, .force_address_valid, .force_address);
    card_adapter_end card_adapter_end_inst (.clk, .sys_rst, .link(card_link_if_inst), .word_data,
        .word_valid, .last_word, .word_ready, .load_active);
    card_load_sva card_load_sva_inst (.clk, .sys_rst, .operation_active(card_link_if_inst.operation_active),
        .head_position_signal(card_link_if_inst.head_position_signal),
        .adapter_output_strobe(card_link_if_inst.adapter_output_strobe),
        .card_input_done(card_link_if_inst.card_input_done), .power_on_reset, .reset_load_button,
        .load_stop, .console_state_flag, .null_state, .load_master_clear, .first_nybble_flag,
        .last_nybble_flag, .assembly_clear, .word_store_trigger, .panel_store_request,
        .reset_clear_first, .exec_request);
    // =====================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("BAD %0t timeout", $time);
        close_out();
    end
    // =====================================
    // tasks
    task close_out;
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    function logic sel(input int k);
        case (k)
            0: return word_store_trigger;
            1: return exec_request;
            2: return reset_clear_first;
            4: return force_address_valid;
            default: return word_ready;
        endcase
    endfunction : sel
    task wait_for(input int k, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sel(k) !== 1'b1 && n < lim);
        chk(16'(sel(k)), 16'h0001);
    endtask : wait_for
    task pulse(input int k);
        @(posedge clk);
        case (k)
            0: reset_load_button <= 1'b1;
            1: autoload_button <= 1'b1;
            2: disc_autoload_request <= 1'b1;
            3: null_state <= 1'b1;
            4: power_on_reset <= 1'b1;
            default: {load_stop, console_state_flag} <= 2'h3;
        endcase
        @(posedge clk);
        {reset_load_button, autoload_button, disc_autoload_request, null_state} <= 4'h0;
        {power_on_reset, load_stop, console_state_flag} <= 3'h0;
    endtask : pulse
    task send_word(input logic [15:0] w, input logic last);
        @(posedge clk);
        word_data <= w;
        last_word <= last;
        word_valid <= 1'b1;
        wait_for(3, 100);
        chk(16'(load_active), 16'h0001);
        @(posedge clk);
        word_valid <= 1'b0;
        wait_for(0, 100);
        chk(console_data, w);
        @(negedge clk);
        chk(16'(panel_store_request), 16'h0001);
        pulse(5);
        @(negedge clk);
        chk(16'(panel_store_request), 16'h0000);
    endtask : send_word
    task clear_exec;
        repeat (4) @(negedge clk);
        pulse(3);
        @(negedge clk);
        chk(16'(exec_request), 16'h0000);
    endtask : clear_exec
    // =====================================
    // tests
    initial begin
        {sys_rst, card_source_selected} = 2'h3;
        {power_on_reset, reset_load_button, autoload_button, auto_mode, disc_autoload_request} = 5'h00;
        {disc_load_done, load_stop, console_state_flag, null_state, word_valid, last_word} = 6'h00;
        word_data = 16'h0000;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(disc_source_select), 16'h0000);
        pulse(0);
        @(negedge clk);
        chk(16'(card_link_if_inst.operation_active), 16'h0001);
        send_word(16'hA5C3, 1'b0);
        send_word(16'h1234, 1'b1);
        chk(16'(card_link_if_inst.operation_active), 16'h0000);
        repeat (20) @(negedge clk);
        chk(16'(reset_clear_first), 16'h0000);
        chk(16'(exec_request), 16'h0000);
        pulse(1);
        wait_for(1, 200);
        chk(force_address, 16'h0112);
        @(negedge clk);
        chk(16'(busy_active[4]), 16'h0001);
        chk(16'(request_enable), 16'h0001);
        wait_for(4, 8);
        clear_exec();
        wait_for(1, 260);
        clear_exec();
        @(posedge clk);
        card_source_selected <= 1'b0;
        pulse(2);
        wait_for(1, 200);
        chk(force_address, 16'h0113);
        chk(16'(disc_source_select), 16'h0001);
        clear_exec();
        @(posedge clk);
        card_source_selected <= 1'b1;
        auto_mode <= 1'b1;
        pulse(4);
        send_word(16'h0F0F, 1'b1);
        wait_for(2, 50);
        chk(16'(reset_clear_second), 16'h0001);
        close_out();
    end
endmodule : tb_card_store_load_and_autoload
